// [nttme_pkg.sv]
// Constants and types for the test-mode entry and connectivity chain block
package nttme_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int FAST_RESET_CYCLES = 14;
	localparam int NORMAL_RESET_US = 1000;
	localparam int NORMAL_RESET_CYCLES = (NORMAL_RESET_US * 1000000) / CLK_PERIOD_PS;
	localparam int CNT_W = 18;
	// ****************************************
	// Chains and straps
	// ****************************************
	localparam int CHAINS = 8;
	localparam int CHAIN_LEN = 8;
	localparam logic [5:0] CODE_TREE_A = 6'h30;
	localparam logic [5:0] CODE_TREE_B = 6'h31;
	localparam logic [5:0] STRAP_RESET = 6'h00;

	typedef enum logic [1:0] {NTTME_NORMAL, NTTME_TREE_A, NTTME_TREE_B} nttme_mode_t;

	typedef struct packed {
		logic [1:0] irq;
		logic [3:0] req;
	} nttme_strap_t;
endpackage

// [nttme_top.sv]
// Test-mode entry, fast processor reset and connectivity chains
`timescale 1ns/1ps
`default_nettype none
module nttme_top #(
	parameter int NORMAL_CYCLES = nttme_pkg::NORMAL_RESET_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Reset and mode pins
	input wire logic resume_well_reset_n,
	input wire logic test_enable_n,
	input wire logic bus_reset_in_n,
	input wire nttme_pkg::nttme_strap_t strap_in,
	// Chain inputs, one row per tree A chain
	input wire logic [nttme_pkg::CHAINS*nttme_pkg::CHAIN_LEN-1:0] chain_in,
	// Result bus, two-way
	input wire logic [7:0] chain_result_bus_in,
	output logic [7:0] chain_result_bus_out,
	output logic [7:0] chain_result_bus_oe,
	// Processor reset and status
	output logic processor_reset_out_n,
	output logic fast_reset_mode,
	output nttme_pkg::nttme_mode_t test_mode
);
	// ****************************************
	// Chain evaluation
	// ****************************************
	// Each stage nands its pin with the previous stage; a seed of one makes stage 0 an inverter.
	// With pins pulled low one after another from stage 0 up, every new zero flips the end,
	// which a single isolated zero would not do on every stage.
	function automatic logic nand_chain(input logic [nttme_pkg::CHAIN_LEN-1:0] pins);
		logic acc;
		acc = 1'b1;
		for (int i = 0; i < nttme_pkg::CHAIN_LEN; i++) begin
			acc = ~(acc & pins[i]);
		end
		return acc;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] wake_sync_ff, test_sync_ff, bus_rst_sync_ff;
	logic wake_prev_ff;
	nttme_pkg::nttme_strap_t strap_s1_ff, strap_s2_ff;
	logic [nttme_pkg::CHAINS*nttme_pkg::CHAIN_LEN-1:0] chain_s1_ff, chain_s2_ff;
	logic [7:0] sd_s1_ff, sd_s2_ff;

	// Two stages for every pin; only the second is read by logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_sync_ff <= 2'h0;
			test_sync_ff <= 2'h3;
			bus_rst_sync_ff <= 2'h0;
			wake_prev_ff <= 1'b0;
			strap_s1_ff <= nttme_pkg::STRAP_RESET;
			strap_s2_ff <= nttme_pkg::STRAP_RESET;
			chain_s1_ff <= '1;
			chain_s2_ff <= '1;
			sd_s1_ff <= 8'hff;
			sd_s2_ff <= 8'hff;
		end else begin
			wake_sync_ff <= {wake_sync_ff[0], resume_well_reset_n};
			test_sync_ff <= {test_sync_ff[0], test_enable_n};
			bus_rst_sync_ff <= {bus_rst_sync_ff[0], bus_reset_in_n};
			wake_prev_ff <= wake_sync_ff[1];
			strap_s1_ff <= strap_in;
			strap_s2_ff <= strap_s1_ff;
			chain_s1_ff <= chain_in;
			chain_s2_ff <= chain_s1_ff;
			sd_s1_ff <= chain_result_bus_in;
			sd_s2_ff <= sd_s1_ff;
		end
	end

	logic wake_rise;
	assign wake_rise = wake_sync_ff[1] & ~wake_prev_ff;

	// ****************************************
	// Fast reset latch
	// ****************************************
	logic fast_ff;
	// Sampled on the wake edge using only the reference clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fast_ff <= 1'b0;
		end else if (wake_rise) begin
			fast_ff <= ~test_sync_ff[1];
		end
	end

	// ****************************************
	// Strap latch and mode decode
	// ****************************************
	nttme_pkg::nttme_strap_t strap_ff;
	nttme_pkg::nttme_mode_t mode_ff, nxt_mode;

	// Transparent while the test pin is low, holds when high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strap_ff <= nttme_pkg::STRAP_RESET;
		end else if (!test_sync_ff[1]) begin
			strap_ff <= strap_s2_ff;
		end
	end

	// Unknown codes fall back to normal operation
	always_comb begin
		unique case (strap_ff)
			nttme_pkg::CODE_TREE_A: nxt_mode = nttme_pkg::NTTME_TREE_A;
			nttme_pkg::CODE_TREE_B: nxt_mode = nttme_pkg::NTTME_TREE_B;
			default: nxt_mode = nttme_pkg::NTTME_NORMAL;
		endcase
	end

	// Mode follows the latched strap code; cold reset clears it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_ff <= nttme_pkg::NTTME_NORMAL;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// ****************************************
	// Processor reset timer
	// ****************************************
	logic [nttme_pkg::CNT_W-1:0] cnt_ff, limit;
	logic cpu_rst_ff;
	// Limit follows the fast reset latch, which settles long before the bus reset lets go
	assign limit = fast_ff ? nttme_pkg::CNT_W'(nttme_pkg::FAST_RESET_CYCLES) : nttme_pkg::CNT_W'(NORMAL_CYCLES);

	// Count from bus reset release, then release the processor
	always_ff @(posedge ref_clk) begin
		if (rst || !bus_rst_sync_ff[1]) begin
			cnt_ff <= '0;
			cpu_rst_ff <= 1'b1;
		end else if (cnt_ff < limit) begin
			cnt_ff <= cnt_ff + 1'b1;
			cpu_rst_ff <= 1'b1;
		end else begin
			cpu_rst_ff <= 1'b0;
		end
	end

	// ****************************************
	// Chain outputs
	// ****************************************
	logic [7:0] tree_a;
	logic tree_b;
	// Tree B is one chain over the result bus pins; tree A chains feed one bit each
	// Control pins never enter a chain
	always_comb begin
		for (int n = 0; n < nttme_pkg::CHAINS; n++) begin
			tree_a[n] = nand_chain(chain_s2_ff[n*nttme_pkg::CHAIN_LEN +: nttme_pkg::CHAIN_LEN]);
		end
		tree_b = nand_chain(sd_s2_ff);
	end

	logic [7:0] sd_out_ff, sd_oe_ff;
	logic rst_pin_ff;
	// Tree A drives the bus, tree B listens and reports on reset pin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sd_out_ff <= 8'h00;
			sd_oe_ff <= 8'h00;
			rst_pin_ff <= 1'b0;
		end else begin
			sd_out_ff <= (mode_ff == nttme_pkg::NTTME_TREE_A) ? tree_a : 8'h00;
			sd_oe_ff <= (mode_ff == nttme_pkg::NTTME_TREE_A) ? 8'hff : 8'h00;
			rst_pin_ff <= (mode_ff == nttme_pkg::NTTME_TREE_B) ? tree_b : ~cpu_rst_ff;
		end
	end

	assign chain_result_bus_out = sd_out_ff;
	assign chain_result_bus_oe = sd_oe_ff;
	assign processor_reset_out_n = rst_pin_ff;
	assign fast_reset_mode = fast_ff;
	assign test_mode = mode_ff;

	// ****************************************
	// Checks
	// ****************************************
	fast_latch_low_a: assert property (@(posedge ref_clk) disable iff (rst)
		wake_rise && !test_sync_ff[1] |=> fast_ff) else $error("fast mode not latched");
	fast_latch_high_a: assert property (@(posedge ref_clk) disable iff (rst)
		wake_rise && test_sync_ff[1] |=> !fast_ff) else $error("fast mode wrongly latched");
	fast_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		fast_ff && $rose(bus_rst_sync_ff[1]) |-> cpu_rst_ff [*8] ##1 cpu_rst_ff [*7] ##1 !cpu_rst_ff)
		else $error("fast reset length wrong");
	normal_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!fast_ff && cpu_rst_ff && cnt_ff < limit |=> cpu_rst_ff) else $error("normal reset released early");
	latch_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		test_sync_ff[1] |=> $stable(strap_ff)) else $error("strap latch moved while closed");
	tree_a_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		strap_ff == nttme_pkg::CODE_TREE_A |=> mode_ff == nttme_pkg::NTTME_TREE_A ##1 sd_oe_ff == 8'hff)
		else $error("tree A not entered");
	tree_b_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		strap_ff == nttme_pkg::CODE_TREE_B |=> mode_ff == nttme_pkg::NTTME_TREE_B ##1 sd_oe_ff == 8'h00)
		else $error("tree B not entered");
	chain_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_ff == nttme_pkg::NTTME_TREE_A |=> sd_out_ff == $past(tree_a)) else $error("chain bit mismatch");
	tree_b_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_ff == nttme_pkg::NTTME_TREE_B |=> rst_pin_ff == $past(tree_b)) else $error("tree B result wrong");
	other_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		strap_ff != nttme_pkg::CODE_TREE_A && strap_ff != nttme_pkg::CODE_TREE_B
		|=> mode_ff == nttme_pkg::NTTME_NORMAL) else $error("undefined code left normal mode");
	// ****************************************
	// Output ownership, fast latch hold and cold reset checks
	// ****************************************
	reset_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_ff != nttme_pkg::NTTME_TREE_B |=> rst_pin_ff == !$past(cpu_rst_ff)) else $error("reset pin wrong");
	fast_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
		!wake_rise |=> $stable(fast_ff)) else $error("fast mode moved without wake edge");
	cold_clear_a: assert property (@(posedge ref_clk)
		rst |=> !fast_ff && mode_ff == nttme_pkg::NTTME_NORMAL && sd_oe_ff == 8'h00) else $error("cold reset state wrong");
	bus_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_ff != nttme_pkg::NTTME_TREE_A |=> sd_oe_ff == 8'h00 && sd_out_ff == 8'h00) else $error("result bus driven");
	tree_a_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_ff == nttme_pkg::NTTME_TREE_A |=> sd_oe_ff == 8'hff) else $error("tree A bus not driven");
endmodule
`default_nettype wire

// [nttme_tester.sv]
// Tester model driving mode pins, straps and chain inputs
`timescale 1ns/1ps
`default_nettype none
module nttme_tester (
	// Clock
	input wire logic ref_clk,
	// Mode and reset pins
	output logic resume_well_reset_n,
	output logic test_enable_n,
	output logic bus_reset_in_n,
	output nttme_pkg::nttme_strap_t strap_in,
	// Chain pins, idle high so chains start all ones
	output logic [63:0] chain_in,
	output logic [7:0] bus_drv
);
	// Power-up levels
	initial begin
		resume_well_reset_n = 0;
		test_enable_n = 1;
		bus_reset_in_n = 0;
		strap_in = '0;
		chain_in = '1;
		bus_drv = '1;
	end
	// Strap code held from the start, so one test pin pulse sets both modes
	// cold start order
	task automatic cold(input logic tst, input logic [5:0] code);
		resume_well_reset_n = 0;
		bus_reset_in_n = 0;
		test_enable_n = tst;
		strap_in = code;
		repeat (6) @(negedge ref_clk);
		resume_well_reset_n = 1;
		repeat (6) @(negedge ref_clk);
		test_enable_n = 1;
		bus_reset_in_n = 1;
	endtask
endmodule
`default_nettype wire

// [tb_nttme_top.sv]
// Self-checking bench for test-mode entry and connectivity chains
`timescale 1ns/1ps
`default_nettype none
module tb_nttme_top;
	localparam int NORM = 40;
	logic ref_clk = 0;
	logic rst = 1;
	logic resume_well_reset_n, test_enable_n, bus_reset_in_n, processor_reset_out_n, fast_reset_mode;
	nttme_pkg::nttme_strap_t strap_in;
	nttme_pkg::nttme_mode_t test_mode;
	logic [63:0] chain_in;
	logic [7:0] bus_drv, chain_result_bus_out, chain_result_bus_oe, chain_result_bus_in;
	int n_fail = 0;
	int num_checks = 0;
	// Pin level: the design wins where it drives, else the tester
	assign chain_result_bus_in = (chain_result_bus_oe & chain_result_bus_out) | (~chain_result_bus_oe & bus_drv);
	initial forever #2.5 ref_clk = ~ref_clk;
	nttme_tester tester (.ref_clk, .resume_well_reset_n, .test_enable_n, .bus_reset_in_n, .strap_in,
		.chain_in, .bus_drv);
	nttme_top #(.NORMAL_CYCLES(NORM)) dut (.ref_clk, .rst, .resume_well_reset_n, .test_enable_n,
		.bus_reset_in_n, .strap_in, .chain_in, .chain_result_bus_in, .chain_result_bus_out,
		.chain_result_bus_oe, .processor_reset_out_n, .fast_reset_mode, .test_mode);
	// *****
	// Helpers
	// *****
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Cold reset, mode entry, then, except for the tree B code, count cycles to processor reset release
	task automatic boot(input logic tst, input logic [5:0] code, output int n);
		rst = 1;
		repeat (4) @(negedge ref_clk);
		rst = 0;
		tester.cold(tst, code);
		n = 0;
		if (code !== nttme_pkg::CODE_TREE_B) begin
			chk("cpu_held", 0, processor_reset_out_n);
			while (processor_reset_out_n !== 1'b1 && n < 100) begin
				@(negedge ref_clk);
				n++;
			end
			if (n == 100) begin
				n_fail++;
				summarize();
			end
		end
	endtask
	// *****
	// Scenarios
	// *****
	task automatic t_fast_a();
		int n;
		boot(0, nttme_pkg::CODE_TREE_A, n);
		chk_rng("fast_rel", nttme_pkg::FAST_RESET_CYCLES, nttme_pkg::FAST_RESET_CYCLES + 6, n);
		chk("fast", 1, fast_reset_mode);
		chk("mode", nttme_pkg::NTTME_TREE_A, test_mode);
		chk("oe", 8'hff, chain_result_bus_oe);
	endtask
	// Zeros pile up pin by pin; each new zero flips only its own result bit
	task automatic t_chain_a();
		logic [7:0] base;
		tester.strap_in = nttme_pkg::CODE_TREE_B;
		repeat (4) @(negedge ref_clk);
		base = chain_result_bus_out;
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 8; p++) begin
				tester.chain_in = ~(((64'h1 << (p + 1)) - 64'h1) << (8 * c));
				repeat (4) @(negedge ref_clk);
				chk("chain_a", p[0] ? base : base ^ (8'h01 << c), chain_result_bus_out);
			end
		end
		tester.chain_in = '1;
		chk("mode_kept", nttme_pkg::NTTME_TREE_A, test_mode);
	endtask
	task automatic t_normal();
		int n;
		boot(1, nttme_pkg::CODE_TREE_A, n);
		chk_rng("norm_rel", NORM, NORM + 6, n);
		chk("fast", 0, fast_reset_mode);
		chk("mode", nttme_pkg::NTTME_NORMAL, test_mode);
	endtask
	// Result bus pins become the single chain, seen on the reset pin
	task automatic t_tree_b();
		int n;
		logic base;
		boot(0, nttme_pkg::CODE_TREE_B, n);
		chk("mode", nttme_pkg::NTTME_TREE_B, test_mode);
		chk("oe", 0, chain_result_bus_oe);
		repeat (4) @(negedge ref_clk);
		base = processor_reset_out_n;
		for (int p = 0; p < 8; p++) begin
			tester.bus_drv = 8'(~((16'h0001 << (p + 1)) - 16'h0001));
			repeat (4) @(negedge ref_clk);
			chk("chain_b", {7'h0, base ^ ~p[0]}, processor_reset_out_n);
		end
		tester.bus_drv = '1;
	endtask
	task automatic t_codes();
		logic [5:0] codes [3] = '{6'h10, 6'h20, 6'h32};
		int n;
		foreach (codes[i]) begin
			boot(0, codes[i], n);
			chk("mode", nttme_pkg::NTTME_NORMAL, test_mode);
		end
	endtask
	// Main sequence
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 0;
		t_fast_a();
		t_chain_a();
		t_normal();
		t_tree_b();
		t_codes();
		summarize();
	end
endmodule
`default_nettype wire
